// ### rtl/power_mode_clock_tree.sv
/*
  Power-mode controller and clock tree: derives the pipeline, internal
  bus, core bus, peripheral bus, expansion bus and sdram clocks, gates
  them by power mode and by bus activity, and holds a small register set.
  Assumes i_clk is the free-running reference standing for the pll output,
  core requests and access levels are on i_clk, pins and oscillators are not.
*/
// Added by the designer: strobed register access and the placing of the registers.
// Functional notes
// R1 - reset and default mode is fullspeed
// R2 - standby instruction holds pipeline clock high
// R3 - standby keeps all peripheral clocks running
// R4 - any interrupt leaves standby to fullspeed
// R5 - suspend holds pipeline, stops bus clocks
// R6 - suspend keeps register and cache contents
// R7 - power-on factor or masked irq leaves suspend
// R8 - hibernate holds clocks high, stops pll
// R9 - hibernate contents lost, software told
// R10 - power-on factor or masked irq leaves hibernate
// R11 - software self-refreshes dram before deep modes
// R12 - main oscillator sources core and peripheral clocks
// R13 - rtc oscillator clocks power manager timekeeping
// R14 - pipeline ratio chosen by three select pins
// R15 - core bus clock quarter rate, counts timer
// R16 - internal bus clock 1/1, 1/2, 1/3, default half
// R17 - peripheral clock divided, toggles only on access
// R18 - expansion clock divided, toggles only externally
// R19 - sdram clock at bus rate during accesses
// R20 - gate and re-ratio only at low phase
// R21 - hibernate wake waits for pll lock
`timescale 1ns/1ps
`include "pm_clk_consts.svh"
module power_mode_clock_tree #(
  parameter int IRQ_W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // power instructions and interrupts from the core
  input wire logic i_standby_req,
  input wire logic i_suspend_req,
  input wire logic i_hibernate_req,
  input wire logic [IRQ_W-1:0] i_irq,
  // pins and oscillator side
  input wire logic [2:0] i_pll_ratio_select_pins,
  input wire logic i_power_on_factor,
  input wire logic i_rtc_osc_in,
  input wire logic i_pll_lock,
  // bus activity from the controllers
  input wire logic i_periph_access,
  input wire logic i_ext_access,
  input wire logic i_sdram_access,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // derived clocks
  output logic o_pipeline_clock,
  output logic o_internal_bus_clock,
  output logic o_core_bus_clock,
  output logic o_periph_bus_clock,
  output logic o_expansion_bus_clock,
  output logic o_sdram_clock_out,
  // power state
  output logic o_pll_enable,
  output pm_clk_pkg::pm_mode_t o_power_mode,
  output logic o_state_retained
);
  import pm_clk_pkg::*;

  pm_mode_t mode_q;
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic rtc_last_q;
  logic [2:0] sel_s;
  logic pof_s;
  logic rtc_s;
  logic lock_s;
  logic [5:0] div_q;
  logic [IRQ_W-1:0] wmask_q;
  logic lost_q;
  logic [31:0] count_q;
  logic [31:0] rtc_count_q;
  logic [31:0] rdata_q;
  logic wake_deep;
  logic clk_on;
  div_ratio_t pipe_div;
  div_ratio_t ibus_div;
  logic [`CH_NUM-1:0] src_a;
  logic [`CH_NUM-1:0] run_a;
  div_ratio_t ratio_a [`CH_NUM];
  logic [`CH_NUM-1:0] clk_a;
  logic [`CH_NUM-1:0] edge_a;
  logic [`CH_NUM-1:0] rise_a;

  // pins and oscillator pass two flops; only the second stage is read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
    end else begin
      meta_q <= {i_pll_ratio_select_pins, i_power_on_factor, i_rtc_osc_in, i_pll_lock};
      sync_q <= meta_q;
    end
  end
  assign sel_s = sync_q[5:3];
  assign pof_s = sync_q[2];
  assign rtc_s = sync_q[1];
  assign lock_s = sync_q[0];

  // deep modes wake on a power-on factor or an unmasked interrupt
  assign wake_deep = pof_s || (|(i_irq & wmask_q)); // R7 R10

  // power mode sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= st_full; // R1
    end else begin
      case (mode_q)
        st_full: begin
          if (i_hibernate_req) begin
            mode_q <= st_hibernate; // R8
          end else if (i_suspend_req) begin
            mode_q <= st_suspend; // R5
          end else if (i_standby_req) begin
            mode_q <= st_standby; // R2
          end
        end
        st_standby: begin
          if (|i_irq) begin
            mode_q <= st_full; // R4
          end
        end
        st_suspend: begin
          if (wake_deep) begin
            mode_q <= st_full; // R7
          end
        end
        st_hibernate: begin
          if (wake_deep) begin
            mode_q <= st_relock; // R10
          end
        end
        st_relock: begin
          // every clock stays held until the restarted pll reports lock
          if (lock_s) begin
            mode_q <= st_full; // R21
          end
        end
        default: begin
          mode_q <= st_full;
        end
      endcase
    end
  end

  // pll runs from the main oscillator in every mode but hibernate
  assign o_pll_enable = (mode_q != st_hibernate); // R8 R12
  // suspend keeps core state; hibernate and relock do not
  assign o_state_retained = (mode_q != st_hibernate) && (mode_q != st_relock); // R6 R9
  assign o_power_mode = mode_q;

  // peripheral side clocks live in fullspeed and standby alike
  assign clk_on = (mode_q == st_full) || (mode_q == st_standby); // R3 R5

  // pipeline half-period from the select pins, one to eight ref cycles
  assign pipe_div = div_ratio_t'({5'h00, sel_s}) + `RATIO_1; // R14

  // internal bus ratio code: 0 is 1/1, 2 is 1/3, others 1/2
  always_comb begin
    case (div_q[`DIV_IBUS_LSB +: `DIV_FLD_W])
      2'h0: ibus_div = `RATIO_1;
      2'h2: ibus_div = `RATIO_3;
      default: ibus_div = `RATIO_2;
    endcase
  end

  // channel wiring; the internal bus counts ref edges directly so that
  // it keeps running while the pipeline clock is held in standby
  always_comb begin
    src_a[`CH_PIPE] = 1'b1;
    run_a[`CH_PIPE] = (mode_q == st_full); // R2 R5 R8
    ratio_a[`CH_PIPE] = pipe_div; // R14
    src_a[`CH_IBUS] = 1'b1;
    run_a[`CH_IBUS] = clk_on; // R3 R5
    ratio_a[`CH_IBUS] = div_ratio_t'(pipe_div * ibus_div); // R16
    src_a[`CH_CORE] = edge_a[`CH_IBUS];
    run_a[`CH_CORE] = clk_on;
    ratio_a[`CH_CORE] = `CORE_BUS_DIV; // R15
    src_a[`CH_PERI] = edge_a[`CH_IBUS];
    run_a[`CH_PERI] = clk_on && (i_periph_access || i_ext_access); // R17
    ratio_a[`CH_PERI] = div_ratio_t'({6'h00, div_q[`DIV_PERI_LSB +: `DIV_FLD_W]}) + `RATIO_1;
    src_a[`CH_EXP] = edge_a[`CH_PERI];
    run_a[`CH_EXP] = clk_on && i_ext_access; // R18
    ratio_a[`CH_EXP] = div_ratio_t'({6'h00, div_q[`DIV_EXP_LSB +: `DIV_FLD_W]}) + `RATIO_1;
    src_a[`CH_SDR] = edge_a[`CH_IBUS];
    run_a[`CH_SDR] = clk_on && i_sdram_access; // R19
    ratio_a[`CH_SDR] = `RATIO_1;
  end

  // one divider per derived clock
  clk_div_if ch [`CH_NUM] ();
  for (genvar k = 0; k < `CH_NUM; k++) begin : g_ch
    assign ch[k].src_edge = src_a[k];
    assign ch[k].run = run_a[k];
    assign ch[k].ratio = ratio_a[k];
    assign clk_a[k] = ch[k].clk;
    assign edge_a[k] = ch[k].edge_p;
    assign rise_a[k] = ch[k].rise_p;
    clk_divider u_div (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .d(ch[k])
    );
  end

  assign o_pipeline_clock = clk_a[`CH_PIPE];
  assign o_internal_bus_clock = clk_a[`CH_IBUS];
  assign o_core_bus_clock = clk_a[`CH_CORE];
  assign o_periph_bus_clock = clk_a[`CH_PERI];
  assign o_expansion_bus_clock = clk_a[`CH_EXP];
  assign o_sdram_clock_out = clk_a[`CH_SDR];

  // divider ratio codes; reset selects internal bus at half rate
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= `DIV_RST; // R16
    end else if (i_reg_wr && (i_reg_addr == `ADDR_DIV)) begin
      div_q <= i_reg_wdata[5:0];
    end
  end

  // deep-mode wake mask, all interrupts blocked after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wmask_q <= '0;
    end else if (i_reg_wr && (i_reg_addr == `ADDR_WMASK)) begin
      wmask_q <= i_reg_wdata[IRQ_W-1:0];
    end
  end

  // contents-lost flag: set on hibernate wake, write one to clear;
  // a set in the clearing cycle wins so a wake is never missed
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lost_q <= 1'b0;
    end else if ((mode_q == st_hibernate) && wake_deep) begin
      lost_q <= 1'b1; // R9
    end else if (i_reg_wr && (i_reg_addr == `ADDR_STAT) && i_reg_wdata[`ST_LOST_BIT]) begin
      lost_q <= 1'b0;
    end
  end

  // timer count steps once per core bus clock rise; a write takes priority
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= 32'h0000_0000;
    end else if (i_reg_wr && (i_reg_addr == `ADDR_COUNT)) begin
      count_q <= i_reg_wdata;
    end else if (rise_a[`CH_CORE]) begin
      count_q <= count_q + 32'h0000_0001; // R15
    end
  end

  // rtc oscillator keeps time in every mode, hibernate included
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rtc_last_q <= 1'b0;
      rtc_count_q <= 32'h0000_0000;
    end else begin
      rtc_last_q <= rtc_s;
      if (rtc_s && !rtc_last_q) begin
        rtc_count_q <= rtc_count_q + 32'h0000_0001; // R13
      end
    end
  end

  // read data stand only in the cycle after the strobe, unmapped reads zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `ADDR_DIV: rdata_q <= {26'h000_0000, div_q};
        `ADDR_WMASK: rdata_q <= 32'(wmask_q);
        `ADDR_STAT: rdata_q <= {16'h0000, ratio_a[`CH_PIPE], 3'h0, lost_q, lock_s, mode_q};
        `ADDR_COUNT: rdata_q <= count_q;
        `ADDR_RTC: rdata_q <= rtc_count_q;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign o_reg_rdata = rdata_q;

  chk_standby_entry: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
    (mode_q == st_full && i_standby_req && !i_suspend_req && !i_hibernate_req)
      |=> (mode_q == st_standby)) else $error("standby request not taken");
  chk_pipe_stays_held: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
    (mode_q != st_full && o_pipeline_clock) |=> o_pipeline_clock)
    else $error("pipeline clock toggled outside fullspeed");
  chk_standby_bus_runs: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
    (mode_q == st_standby)[*2] |-> run_a[`CH_IBUS] && run_a[`CH_CORE])
    else $error("bus clocks stopped in standby");
  chk_standby_wake: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
    (mode_q == st_standby && |i_irq) |=> (mode_q == st_full))
    else $error("interrupt did not end standby");
  chk_suspend_bus_held: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5
    (mode_q == st_suspend && o_internal_bus_clock) |=> o_internal_bus_clock)
    else $error("internal bus clock toggled in suspend");
  chk_deep_wake: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
    (mode_q == st_suspend && wake_deep) |=> (mode_q == st_full))
    else $error("wake factor did not end suspend");
  chk_pll_off: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
    (i_hibernate_req && mode_q == st_full) |=> !o_pll_enable ##0 !o_state_retained)
    else $error("pll still enabled in hibernate");
  chk_relock_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R21
    (mode_q == st_relock && !lock_s) |=> (mode_q == st_relock) && o_pll_enable)
    else $error("left relock before pll lock");
  chk_timer_step: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
    (rise_a[`CH_CORE] && !(i_reg_wr && i_reg_addr == `ADDR_COUNT))
      |=> (count_q == $past(count_q) + 32'h0000_0001)) else $error("timer count missed a step");
  chk_periph_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
    (!i_periph_access && !i_ext_access && o_periph_bus_clock) |=> o_periph_bus_clock)
    else $error("peripheral clock toggled without access");
endmodule

// ### rtl/pm_clk_consts.svh
/*
  Named constants of the power-mode clock tree: register offsets, field
  positions, reset values and fixed divider ratios.
  Assumes it is included by its bare name after the package is compiled.
*/
`ifndef PM_CLK_CONSTS_SVH
`define PM_CLK_CONSTS_SVH

// register offsets on the plain register port
`define ADDR_DIV 8'h00
`define ADDR_WMASK 8'h04
`define ADDR_STAT 8'h08
`define ADDR_COUNT 8'h0C
`define ADDR_RTC 8'h10

// divider control register: three 2-bit ratio codes
`define DIV_FLD_W 2
`define DIV_IBUS_LSB 0
`define DIV_PERI_LSB 2
`define DIV_EXP_LSB 4
`define DIV_RST 6'h01

// status register fields
`define ST_MODE_LSB 0
`define ST_LOCK_BIT 3
`define ST_LOST_BIT 4
`define ST_PDIV_LSB 8

// divider ratios, counted in source edges per output half period
`define RATIO_1 8'h01
`define RATIO_2 8'h02
`define RATIO_3 8'h03
`define CORE_BUS_DIV 8'h04

// level a stopped clock rests at
`define CLK_IDLE 1'b1

// divider channel indices
`define CH_PIPE 0
`define CH_IBUS 1
`define CH_CORE 2
`define CH_PERI 3
`define CH_EXP 4
`define CH_SDR 5
`define CH_NUM 6

`endif

// ### rtl/pm_clk_pkg.sv
/*
  Types shared by the power-mode clock tree and its divider channels.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pm_clk_pkg;
  // power modes, gray coded along full -> standby -> suspend -> hibernate -> relock
  typedef enum logic [2:0] {
    st_full = 3'h0,
    st_standby = 3'h1,
    st_suspend = 3'h3,
    st_hibernate = 3'h2,
    st_relock = 3'h6
  } pm_mode_t;
  typedef logic [7:0] div_ratio_t;
endpackage

// ### rtl/clk_div_if.sv
/*
  Carrier between the clock tree and one divider channel.
  Assumes the clock tree drives source, run and ratio on i_clk.
*/
`timescale 1ns/1ps
interface clk_div_if;
  import pm_clk_pkg::*;
  logic src_edge;
  logic run;
  div_ratio_t ratio;
  logic clk;
  logic edge_p;
  logic rise_p;
  modport ctrl (output src_edge, run, ratio, input clk, edge_p, rise_p);
  modport div (input src_edge, run, ratio, output clk, edge_p, rise_p);
endinterface

// ### rtl/clk_divider.sv
/*
  One glitch-free clock divider channel: toggles its output every ratio
  source edges, rests high when stopped, takes a new ratio only at the
  start of a low phase.
  Assumes source edges are one-cycle pulses on i_clk and ratio is nonzero.
*/
`timescale 1ns/1ps
`include "pm_clk_consts.svh"
module clk_divider (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // channel carrier
  clk_div_if.div d
);
  import pm_clk_pkg::*;

  div_ratio_t cnt_q;
  div_ratio_t ratio_q;
  logic q_q;
  logic edge_q;
  logic rise_q;
  logic hit;
  logic flip;

  // a half period ends on the ratio-th source edge
  assign hit = d.src_edge && (cnt_q >= ratio_q - `RATIO_1);
  // a stopped clock may still finish its low phase, never start one
  assign flip = hit && (d.run || !q_q); // R20

  // half-period counter
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
    end else if (hit) begin
      cnt_q <= 8'h00;
    end else if (d.src_edge) begin
      cnt_q <= cnt_q + `RATIO_1;
    end
  end

  // output level, rests high while stopped
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_q <= `CLK_IDLE;
    end else if (flip) begin
      q_q <= !q_q; // R20
    end
  end

  // ratio is latched as the low phase begins, so no half period is cut
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ratio_q <= `RATIO_1;
    end else if (flip && q_q) begin
      ratio_q <= (d.ratio == 8'h00) ? `RATIO_1 : d.ratio; // R20
    end
  end

  // half-period ticks for downstream channels; they go on while this
  // channel rests, so a child caught low still finishes its low phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      edge_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      edge_q <= hit; // R8 R20
      rise_q <= flip && !q_q;
    end
  end

  assign d.clk = q_q;
  assign d.edge_p = edge_q;
  assign d.rise_p = rise_q;

  chk_hold_stopped_high: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R20
    (!d.run && q_q) |=> q_q) else $error("stopped clock left its high rest level");
  chk_ratio_low_phase: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R20
    $changed(ratio_q) |-> (!q_q && $past(q_q))) else $error("ratio changed outside low phase start");
  chk_edge_marks_flip: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $changed(q_q) |-> (edge_q && (rise_q == q_q))) else $error("edge marker missing on toggle");
endmodule

// ### tb/pm_core_model.sv
/*
  Behavioural stand-in for the core and the pll beside the clock tree:
  turns bench commands into power instruction pulses and reports lock.
  Assumes commands are one-cycle codes on the reference clock.
*/
`timescale 1ns/1ps
module pm_core_model #(
  parameter int LOCK_CYC = 40
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // bench commands: 1 standby, 2 suspend, 3 hibernate
  input wire logic [1:0] i_cmd,
  input wire logic i_pll_enable,
  // towards the clock tree
  output logic o_standby_req,
  output logic o_suspend_req,
  output logic o_hibernate_req,
  output logic o_pll_lock,
  // dram state
  output logic o_self_refresh
);
  logic [1:0] pend_q;
  int lock_cnt_q;

  // deep modes put dram in self refresh in the same cycle as the instruction pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= 2'h0;
      o_self_refresh <= 1'b0;
    end else begin
      pend_q <= i_cmd;
      if (i_cmd >= 2'h2) begin
        o_self_refresh <= 1'b1;
      end else if (i_cmd == 2'h1) begin
        o_self_refresh <= 1'b0;
      end
    end
  end

  // one-cycle instruction pulses
  assign o_standby_req = (pend_q == 2'h1);
  assign o_suspend_req = (pend_q == 2'h2);
  assign o_hibernate_req = (pend_q == 2'h3);

  // lock is lost at once when the pll stops, and only returns after settling
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_cnt_q <= 0;
    end else if (!i_pll_enable) begin
      lock_cnt_q <= 0;
    end else if (lock_cnt_q < LOCK_CYC) begin
      lock_cnt_q <= lock_cnt_q + 1;
    end
  end
  assign o_pll_lock = i_pll_enable && (lock_cnt_q == LOCK_CYC);
endmodule

// ### tb/power_mode_clock_tree_bench.sv
/*
  Self-checking bench for the power-mode clock tree: register accesses,
  clock period measurements and walks through every power mode.
  Assumes the core model beside it and a 200 MHz reference clock.
*/
`timescale 1ns/1ps
`include "pm_clk_consts.svh"
module power_mode_clock_tree_bench;
  import pm_clk_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] irq = 16'h0000;
  logic [2:0] pins = 3'h0;
  logic pof = 1'b0;
  logic rtc = 1'b0;
  logic pacc = 1'b0;
  logic eacc = 1'b0;
  logic sacc = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic stby, susp, hib, lock, pll_en, kept, sref;
  logic [31:0] rdata, v, w;
  logic [5:0] ck;
  pm_mode_t mode;
  int n;
  int errors = 0;
  int check_count = 0;

  // reference clock and a free-running 32.768 kHz oscillator
  always #2.5 clk = ~clk;
  always #15258.789 rtc = ~rtc;

  power_mode_clock_tree #(.IRQ_W(16)) uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_standby_req(stby), .i_suspend_req(susp),
    .i_hibernate_req(hib), .i_irq(irq), .i_pll_ratio_select_pins(pins),
    .i_power_on_factor(pof), .i_rtc_osc_in(rtc), .i_pll_lock(lock),
    .i_periph_access(pacc), .i_ext_access(eacc), .i_sdram_access(sacc),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_pipeline_clock(ck[`CH_PIPE]),
    .o_internal_bus_clock(ck[`CH_IBUS]), .o_core_bus_clock(ck[`CH_CORE]),
    .o_periph_bus_clock(ck[`CH_PERI]), .o_expansion_bus_clock(ck[`CH_EXP]),
    .o_sdram_clock_out(ck[`CH_SDR]), .o_pll_enable(pll_en), .o_power_mode(mode),
    .o_state_retained(kept)
  );

  pm_core_model #(.LOCK_CYC(40)) core (
    .i_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd), .i_pll_enable(pll_en),
    .o_standby_req(stby), .o_suspend_req(susp), .o_hibernate_req(hib),
    .o_pll_lock(lock), .o_self_refresh(sref)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic mode_is(input pm_mode_t m);
    check("mode", {29'h0, m}, {29'h0, mode});
  endtask

  // ends just past an edge so outputs have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    reg_rd(a, d);
    check(what, exp, d);
  endtask

  task automatic instr(input logic [1:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 2'h0;
  endtask

  // cycles up to the next rising edge of one clock, 500 if none comes
  task automatic rise(input int ch, output int k);
    logic p;
    k = 0;
    do begin
      p = ck[ch];
      @(posedge clk);
      #1;
      k++;
    end while (!(p === 1'b0 && ck[ch] === 1'b1) && k < 500);
  endtask

  // early rises may straddle a ratio change, so only the last one counts
  task automatic per(input int ch, input int exp, input string what);
    int k;
    for (int i = 0; i < 4; i++) begin
      rise(ch, k);
    end
    check(what, exp, k);
  endtask

  task automatic still(input int ch, input string what);
    int k;
    rise(ch, k);
    check(what, 500, k);
    check(what, 1, ck[ch]);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // the walk needs roughly 110 us, mostly waiting on the slow oscillator
  initial begin
    #400_000;
    errors++;
    end_sim();
  end

  initial begin
    cyc(20);
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    mode_is(st_full);
    check("pll_en", 1, pll_en);
    check("kept", 1, kept);
    rd_chk(`ADDR_DIV, 32'h0000_0001, "div");
    rd_chk(`ADDR_WMASK, 32'h0000_0000, "wmask");
    rd_chk(8'h14, 32'h0000_0000, "unmapped");
    cyc(50);
    rd_chk(`ADDR_STAT, 32'h0000_0108, "stat");
    // every select code, default internal bus ratio of one half
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      pins <= 3'(s);
      cyc(40);
      per(`CH_PIPE, 2 * (s + 1), "pipe");
      per(`CH_IBUS, 4 * (s + 1), "ibus");
      per(`CH_CORE, 16 * (s + 1), "core");
    end
    @(posedge clk);
    pins <= 3'h1;
    sacc <= 1'b1;
    eacc <= 1'b1;
    cyc(80);
    for (int c = 0; c < 3; c++) begin
      reg_wr(`ADDR_DIV, 32'(c));
      per(`CH_IBUS, 4 * (c + 1), "ibus");
      per(`CH_SDR, 4 * (c + 1), "sdram");
    end
    for (int p = 0; p < 4; p++) begin
      reg_wr(`ADDR_DIV, 32'(1 + 4 * p + 16 * p));
      per(`CH_PERI, 8 * (p + 1), "periph");
      per(`CH_EXP, 8 * (p + 1) * (p + 1), "exp");
    end
    // bus clocks stand still once their accesses end
    @(posedge clk);
    eacc <= 1'b0;
    pacc <= 1'b1;
    sacc <= 1'b0;
    cyc(300);
    still(`CH_EXP, "exp_idle");
    still(`CH_SDR, "sdram_idle");
    per(`CH_PERI, 32, "periph");
    @(posedge clk);
    pacc <= 1'b0;
    cyc(300);
    still(`CH_PERI, "periph_idle");
    // standby, a refused suspend, then wake on any interrupt
    reg_wr(`ADDR_DIV, 32'h0000_0001);
    instr(2'h1);
    cyc(20);
    mode_is(st_standby);
    still(`CH_PIPE, "pipe_stby");
    per(`CH_IBUS, 8, "ibus_stby");
    per(`CH_CORE, 32, "core_stby");
    instr(2'h2);
    cyc(5);
    mode_is(st_standby);
    @(posedge clk);
    irq <= 16'h8000;
    cyc(3);
    mode_is(st_full);
    @(posedge clk);
    irq <= 16'h0000;
    per(`CH_PIPE, 4, "pipe_wake");
    // suspend wakes only on an enabled interrupt
    reg_wr(`ADDR_WMASK, 32'h0000_0020);
    @(posedge clk);
    pacc <= 1'b1;
    instr(2'h2);
    cyc(20);
    mode_is(st_suspend);
    check("kept", 1, kept);
    check("sref", 1, sref);
    still(`CH_PIPE, "pipe_susp");
    still(`CH_IBUS, "ibus_susp");
    still(`CH_PERI, "periph_susp");
    @(posedge clk);
    irq <= 16'h0004;
    cyc(5);
    mode_is(st_suspend);
    @(posedge clk);
    irq <= 16'h0020;
    cyc(3);
    mode_is(st_full);
    @(posedge clk);
    irq <= 16'h0000;
    pacc <= 1'b0;
    rd_chk(`ADDR_WMASK, 32'h0000_0020, "wmask_kept");
    // timer count steps once per core bus period
    rise(`CH_CORE, n);
    reg_rd(`ADDR_COUNT, v);
    for (int i = 0; i < 4; i++) begin
      rise(`CH_CORE, n);
    end
    reg_rd(`ADDR_COUNT, w);
    check("count", v + 32'h0000_0004, w);
    // hibernate, wake on power-on factor through relock
    instr(2'h3);
    cyc(20);
    mode_is(st_hibernate);
    check("pll_en", 0, pll_en);
    check("clocks", 32'h0000_003f, {26'h0, ck});
    check("kept", 0, kept);
    still(`CH_CORE, "core_hib");
    @(posedge clk);
    pof <= 1'b1;
    cyc(8);
    mode_is(st_relock);
    check("clocks", 32'h0000_003f, {26'h0, ck});
    @(posedge clk);
    pof <= 1'b0;
    cyc(60);
    mode_is(st_full);
    rd_chk(`ADDR_STAT, 32'h0000_0218, "stat_lost");
    reg_wr(`ADDR_STAT, 32'h0000_0010);
    rd_chk(`ADDR_STAT, 32'h0000_0208, "stat_clr");
    // slow oscillator edges are counted
    @(posedge rtc);
    cyc(6);
    reg_rd(`ADDR_RTC, v);
    @(posedge rtc);
    cyc(6);
    reg_rd(`ADDR_RTC, w);
    check("rtc", v + 32'h0000_0001, w);
    // a second reset from standby lands in fullspeed with defaults
    reg_wr(`ADDR_DIV, 32'h0000_0002);
    instr(2'h1);
    cyc(5);
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(3);
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    mode_is(st_full);
    rd_chk(`ADDR_DIV, 32'h0000_0001, "div_rst");
    end_sim();
  end
endmodule
